// ===== src/mcbrg_core.sv
// Design: two-wire master start/restart/stop with collision detection and baud divider
`default_nettype none
module mcbrg_core (
	input wire logic core_clk_in,
	input wire logic reset_in,
	input wire logic [3:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [7:0] reg_rdata_out,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_out,
	input wire logic scl_in,
	output logic scl_out,
	output logic scl_oe_out,
	output logic irq_out
);
	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		mcbrg_pkg::mcbrg_state_t st;
		logic [7:0] cnt;
		logic pre;
		logic run;
		logic [7:0] reload;
		logic [7:0] sbuf;
		logic [7:0] shft;
		logic [3:0] bitc;
		logic tx_high;
		logic [7:0] ctl1;
		logic [7:0] ctl2;
		logic [7:0] ctl3;
		logic [7:0] msk;
		logic [7:0] stat;
		logic [7:0] ie1;
		logic [7:0] ie2;
		logic [7:0] if1;
		logic [7:0] if2;
		mcbrg_pkg::mcbrg_pins_t pins;
		logic [7:0] rdata;
		logic irq;
		logic sda_s1;
		logic sda_s2;
		logic scl_s1;
		logic scl_s2;
	} mcbrg_regs_t;

	mcbrg_regs_t cur_ff;
	mcbrg_regs_t nxt_ff;
	mcbrg_pkg::mcbrg_bus_req_t req;

	logic sda_hi;
	logic scl_hi;
	logic div_done;
	logic twi_mode;
	logic spi_mode;
	logic busy;

	assign req = '{addr: reg_addr_in, wdata: reg_wdata_in, wr: reg_wr_in, rd: reg_rd_in};
	assign sda_hi = cur_ff.sda_s2;
	assign scl_hi = cur_ff.scl_s2;
	// Timeout after reload+1 steps of two clocks each
	assign div_done = cur_ff.run && (cur_ff.pre == mcbrg_pkg::PRESCALE_LAST)
		&& (cur_ff.cnt == mcbrg_pkg::DIV_ZERO);
	assign twi_mode = cur_ff.ctl1[mcbrg_pkg::CTL1_PORT_EN]
		&& (cur_ff.ctl1[3:0] == mcbrg_pkg::MODE_TWI_MASTER);
	assign spi_mode = cur_ff.ctl1[mcbrg_pkg::CTL1_PORT_EN]
		&& (cur_ff.ctl1[3:0] == mcbrg_pkg::MODE_SPI_MASTER_DIV);
	assign busy = cur_ff.st != mcbrg_pkg::ST_IDLE;

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		logic load;
		logic stop_div;
		logic collide;
		logic finish;
		load = 1'b0;
		stop_div = 1'b0;
		collide = 1'b0;
		finish = 1'b0;
		nxt_ff = cur_ff;

		// Pin synchronisers
		nxt_ff.sda_s1 = sda_in;
		nxt_ff.sda_s2 = cur_ff.sda_s1;
		nxt_ff.scl_s1 = scl_in;
		nxt_ff.scl_s2 = cur_ff.scl_s1;

		// Register writes first, so hardware sets below win over clears
		if (req.wr) begin
			unique case (req.addr)
				mcbrg_pkg::ADDR_RELOAD: nxt_ff.reload = req.wdata;
				mcbrg_pkg::ADDR_SHIFT_BUF: begin
					if (busy) begin
						nxt_ff.ctl1[mcbrg_pkg::CTL1_WRITE_COLL] = 1'b1;
					end else begin
						nxt_ff.sbuf = req.wdata;
					end
				end
				mcbrg_pkg::ADDR_CTL_ONE: nxt_ff.ctl1 = req.wdata;
				mcbrg_pkg::ADDR_CTL_TWO: begin
					nxt_ff.ctl2 = req.wdata;
					nxt_ff.ctl2[mcbrg_pkg::CTL2_ACK_STAT] = cur_ff.ctl2[mcbrg_pkg::CTL2_ACK_STAT];
				end
				mcbrg_pkg::ADDR_CTL_THREE: nxt_ff.ctl3 = req.wdata;
				mcbrg_pkg::ADDR_MATCH_MASK: nxt_ff.msk = req.wdata;
				mcbrg_pkg::ADDR_STATUS: nxt_ff.stat[7:6] = req.wdata[7:6];
				mcbrg_pkg::ADDR_IRQ_EN_ONE: nxt_ff.ie1 = req.wdata;
				mcbrg_pkg::ADDR_IRQ_EN_TWO: nxt_ff.ie2 = req.wdata;
				mcbrg_pkg::ADDR_IRQ_FLAG_ONE: nxt_ff.if1 = req.wdata;
				mcbrg_pkg::ADDR_IRQ_FLAG_TWO: nxt_ff.if2 = req.wdata;
				default: ;
			endcase
		end

		// Sequencer
		unique case (cur_ff.st)
			mcbrg_pkg::ST_IDLE: begin
				if (twi_mode && cur_ff.ctl2[mcbrg_pkg::CTL2_START_EN]) begin
					nxt_ff.st = mcbrg_pkg::ST_START_CHK;
				end else if (twi_mode && cur_ff.ctl2[mcbrg_pkg::CTL2_RESTART_EN]) begin
					nxt_ff.pins.sda_oe = 1'b0;
					nxt_ff.st = mcbrg_pkg::ST_RS_SDA;
				end else if (twi_mode && cur_ff.ctl2[mcbrg_pkg::CTL2_STOP_EN]) begin
					nxt_ff.pins.sda_oe = 1'b1;
					nxt_ff.st = mcbrg_pkg::ST_SP_SDA;
				end else if ((twi_mode || spi_mode) && req.wr
					&& req.addr == mcbrg_pkg::ADDR_SHIFT_BUF) begin
					// Divider starts on the buffer write itself
					nxt_ff.shft = req.wdata;
					nxt_ff.bitc = twi_mode ? mcbrg_pkg::TWI_BITS : mcbrg_pkg::SPI_BITS;
					nxt_ff.tx_high = 1'b0;
					nxt_ff.pins.scl_oe = 1'b1;
					nxt_ff.pins.sda_oe = ~req.wdata[7];
					nxt_ff.stat[mcbrg_pkg::STAT_TX_BUSY] = 1'b1;
					nxt_ff.stat[mcbrg_pkg::STAT_BUF_FULL] = 1'b1;
					load = 1'b1;
					nxt_ff.st = mcbrg_pkg::ST_TX;
				end
			end
			mcbrg_pkg::ST_START_CHK: begin
				nxt_ff.pins = '{sda_oe: 1'b0, scl_oe: 1'b0};
				if (!sda_hi || !scl_hi) begin
					collide = 1'b1;
				end else begin
					load = 1'b1;
					nxt_ff.st = mcbrg_pkg::ST_START_CNT1;
				end
			end
			mcbrg_pkg::ST_START_CNT1: begin
				if (!scl_hi && sda_hi) begin
					collide = 1'b1;
				end else if (!sda_hi || div_done) begin
					// Another master took SDA first: assert early and go on to the second count
					nxt_ff.pins.sda_oe = 1'b1;
					load = 1'b1;
					nxt_ff.st = mcbrg_pkg::ST_START_CNT2;
				end
			end
			mcbrg_pkg::ST_START_CNT2: begin
				if (div_done) begin
					nxt_ff.pins.scl_oe = 1'b1;
					nxt_ff.ctl2[mcbrg_pkg::CTL2_START_EN] = 1'b0;
					nxt_ff.stat[mcbrg_pkg::STAT_START_SEEN] = 1'b1;
					nxt_ff.stat[mcbrg_pkg::STAT_STOP_SEEN] = 1'b0;
					finish = 1'b1;
				end
			end
			mcbrg_pkg::ST_RS_SDA: begin
				if (sda_hi) begin
					load = 1'b1;
					nxt_ff.st = mcbrg_pkg::ST_RS_CNT0;
				end
			end
			mcbrg_pkg::ST_RS_CNT0: begin
				if (div_done) begin
					nxt_ff.pins.scl_oe = 1'b0;
					stop_div = 1'b1;
					nxt_ff.st = mcbrg_pkg::ST_RS_SCLH;
				end
			end
			mcbrg_pkg::ST_RS_SCLH: begin
				if (scl_hi) begin
					if (!sda_hi) begin
						collide = 1'b1;
					end else begin
						load = 1'b1;
						nxt_ff.st = mcbrg_pkg::ST_RS_CNT1;
					end
				end
			end
			mcbrg_pkg::ST_RS_CNT1: begin
				// SDA falling here is another master's start, not a loss
				if (!scl_hi && !cur_ff.pins.sda_oe) begin
					collide = 1'b1;
				end else if (div_done) begin
					nxt_ff.pins.sda_oe = 1'b1;
					load = 1'b1;
					nxt_ff.st = mcbrg_pkg::ST_RS_CNT2;
				end
			end
			mcbrg_pkg::ST_RS_CNT2: begin
				if (div_done) begin
					nxt_ff.pins.scl_oe = 1'b1;
					nxt_ff.ctl2[mcbrg_pkg::CTL2_RESTART_EN] = 1'b0;
					nxt_ff.stat[mcbrg_pkg::STAT_START_SEEN] = 1'b1;
					nxt_ff.stat[mcbrg_pkg::STAT_STOP_SEEN] = 1'b0;
					finish = 1'b1;
				end
			end
			mcbrg_pkg::ST_SP_SDA: begin
				if (!sda_hi) begin
					nxt_ff.pins.scl_oe = 1'b0;
					nxt_ff.st = mcbrg_pkg::ST_SP_SCLH;
				end
			end
			mcbrg_pkg::ST_SP_SCLH: begin
				if (scl_hi) begin
					load = 1'b1;
					nxt_ff.st = mcbrg_pkg::ST_SP_CNT0;
				end
			end
			mcbrg_pkg::ST_SP_CNT0: begin
				if (!scl_hi) begin
					collide = 1'b1;
				end else if (div_done) begin
					nxt_ff.pins.sda_oe = 1'b0;
					load = 1'b1;
					nxt_ff.st = mcbrg_pkg::ST_SP_CNT1;
				end
			end
			mcbrg_pkg::ST_SP_CNT1: begin
				if (!scl_hi && !sda_hi) begin
					collide = 1'b1;
				end else if (div_done) begin
					if (!sda_hi) begin
						collide = 1'b1;
					end else begin
						nxt_ff.ctl2[mcbrg_pkg::CTL2_STOP_EN] = 1'b0;
						finish = 1'b1;
					end
				end else if (sda_hi && scl_hi) begin
					nxt_ff.stat[mcbrg_pkg::STAT_STOP_SEEN] = 1'b1;
					nxt_ff.stat[mcbrg_pkg::STAT_START_SEEN] = 1'b0;
				end
			end
			mcbrg_pkg::ST_TX: begin
				// Two reloads per bit: one for each half of the clock
				if (!cur_ff.tx_high && div_done) begin
					nxt_ff.pins.scl_oe = 1'b0;
					nxt_ff.tx_high = 1'b1;
					stop_div = 1'b1;
				end else if (cur_ff.tx_high && !cur_ff.run && scl_hi) begin
					// Clock stretching: high half only starts once SCL is seen high
					load = 1'b1;
					if (twi_mode && cur_ff.bitc == mcbrg_pkg::ACK_SLOT) begin
						nxt_ff.ctl2[mcbrg_pkg::CTL2_ACK_STAT] = sda_hi;
					end
				end else if (cur_ff.tx_high && div_done) begin
					nxt_ff.pins.scl_oe = 1'b1;
					nxt_ff.tx_high = 1'b0;
					nxt_ff.bitc = cur_ff.bitc - 4'h1;
					nxt_ff.shft = {cur_ff.shft[6:0], 1'b1};
					nxt_ff.pins.sda_oe = ~cur_ff.shft[6];
					if (cur_ff.bitc == mcbrg_pkg::ACK_SLOT) begin
						// Clock held low at the end: last level kept
						nxt_ff.pins.sda_oe = cur_ff.pins.sda_oe;
						nxt_ff.stat[mcbrg_pkg::STAT_TX_BUSY] = 1'b0;
						nxt_ff.stat[mcbrg_pkg::STAT_BUF_FULL] = 1'b0;
						finish = 1'b1;
					end else begin
						load = 1'b1;
					end
				end
			end
			default: begin
				collide = 1'b1;
			end
		endcase

		// Collision abort
		if (collide) begin
			nxt_ff.pins = '{sda_oe: 1'b0, scl_oe: 1'b0};
			nxt_ff.ctl2[mcbrg_pkg::CTL2_START_EN] = 1'b0;
			nxt_ff.ctl2[mcbrg_pkg::CTL2_RESTART_EN] = 1'b0;
			nxt_ff.ctl2[mcbrg_pkg::CTL2_STOP_EN] = 1'b0;
			nxt_ff.ctl2[mcbrg_pkg::CTL2_ACK_EN] = 1'b0;
			nxt_ff.stat[mcbrg_pkg::STAT_TX_BUSY] = 1'b0;
			nxt_ff.stat[mcbrg_pkg::STAT_BUF_FULL] = 1'b0;
			nxt_ff.if2[mcbrg_pkg::IRQ_BIT] = 1'b1;
			nxt_ff.st = mcbrg_pkg::ST_IDLE;
			stop_div = 1'b1;
		end
		if (finish) begin
			nxt_ff.if1[mcbrg_pkg::IRQ_BIT] = 1'b1;
			nxt_ff.st = mcbrg_pkg::ST_IDLE;
			stop_div = 1'b1;
		end

		// Port disabled: sequences cancelled, lines released
		if (!cur_ff.ctl1[mcbrg_pkg::CTL1_PORT_EN]) begin
			nxt_ff.st = mcbrg_pkg::ST_IDLE;
			nxt_ff.pins = '{sda_oe: 1'b0, scl_oe: 1'b0};
			nxt_ff.stat[mcbrg_pkg::STAT_STOP_SEEN] = 1'b0;
			nxt_ff.stat[mcbrg_pkg::STAT_START_SEEN] = 1'b0;
			stop_div = 1'b1;
			load = 1'b0;
		end

		// Baud divider: values below three are not usable on the two-wire bus
		if (load) begin
			nxt_ff.cnt = cur_ff.reload;
			nxt_ff.pre = 1'b0;
			nxt_ff.run = 1'b1;
		end else if (stop_div) begin
			nxt_ff.run = 1'b0;
		end else if (cur_ff.run) begin
			nxt_ff.pre = ~cur_ff.pre;
			if (cur_ff.pre == mcbrg_pkg::PRESCALE_LAST && cur_ff.cnt != mcbrg_pkg::DIV_ZERO) begin
				nxt_ff.cnt = cur_ff.cnt - 8'h01;
			end
		end

		nxt_ff.irq = (nxt_ff.if2[mcbrg_pkg::IRQ_BIT] && nxt_ff.ie2[mcbrg_pkg::IRQ_BIT])
			|| (nxt_ff.if1[mcbrg_pkg::IRQ_BIT] && nxt_ff.ie1[mcbrg_pkg::IRQ_BIT]);

		// Read data, valid the cycle after the strobe only
		nxt_ff.rdata = mcbrg_pkg::RESET_BYTE;
		if (req.rd) begin
			unique case (req.addr)
				mcbrg_pkg::ADDR_RELOAD: nxt_ff.rdata = cur_ff.reload;
				mcbrg_pkg::ADDR_SHIFT_BUF: nxt_ff.rdata = cur_ff.sbuf;
				mcbrg_pkg::ADDR_CTL_ONE: nxt_ff.rdata = cur_ff.ctl1;
				mcbrg_pkg::ADDR_CTL_TWO: nxt_ff.rdata = cur_ff.ctl2;
				mcbrg_pkg::ADDR_CTL_THREE: nxt_ff.rdata = cur_ff.ctl3;
				mcbrg_pkg::ADDR_MATCH_MASK: nxt_ff.rdata = cur_ff.msk;
				mcbrg_pkg::ADDR_STATUS: nxt_ff.rdata = cur_ff.stat;
				mcbrg_pkg::ADDR_IRQ_EN_ONE: nxt_ff.rdata = cur_ff.ie1;
				mcbrg_pkg::ADDR_IRQ_EN_TWO: nxt_ff.rdata = cur_ff.ie2;
				mcbrg_pkg::ADDR_IRQ_FLAG_ONE: nxt_ff.rdata = cur_ff.if1;
				mcbrg_pkg::ADDR_IRQ_FLAG_TWO: nxt_ff.rdata = cur_ff.if2;
				default: nxt_ff.rdata = mcbrg_pkg::RESET_BYTE;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	always_ff @(posedge core_clk_in or posedge reset_in) begin
		if (reset_in) begin
			// Synchronisers preset to the released-bus level, so no false low follows reset
			cur_ff <= '{st: mcbrg_pkg::ST_IDLE, sda_s1: 1'b1, sda_s2: 1'b1, scl_s1: 1'b1,
				scl_s2: 1'b1, default: '0};
		end else begin
			cur_ff <= nxt_ff;
		end
	end

	// Open drain: data outputs always low, enable pulls the line
	assign sda_out = 1'b0;
	assign scl_out = 1'b0;
	assign sda_oe_out = cur_ff.pins.sda_oe;
	assign scl_oe_out = cur_ff.pins.scl_oe;
	assign reg_rdata_out = cur_ff.rdata;
	assign irq_out = cur_ff.irq;
endmodule
`default_nettype wire

// ===== common/mcbrg_pkg.sv
// Package: register map, field positions and state encoding for the collision/baud block
`default_nettype none
package mcbrg_pkg;
	// ------------------------------------------------------------
	// Register indices (byte data, all four bits of the address port)
	// ------------------------------------------------------------
	localparam logic [3:0] ADDR_RELOAD = 4'h0;
	localparam logic [3:0] ADDR_SHIFT_BUF = 4'h1;
	localparam logic [3:0] ADDR_CTL_ONE = 4'h2;
	localparam logic [3:0] ADDR_CTL_TWO = 4'h3;
	localparam logic [3:0] ADDR_CTL_THREE = 4'h4;
	localparam logic [3:0] ADDR_MATCH_MASK = 4'h5;
	localparam logic [3:0] ADDR_STATUS = 4'h6;
	localparam logic [3:0] ADDR_IRQ_EN_ONE = 4'h7;
	localparam logic [3:0] ADDR_IRQ_EN_TWO = 4'h8;
	localparam logic [3:0] ADDR_IRQ_FLAG_ONE = 4'h9;
	localparam logic [3:0] ADDR_IRQ_FLAG_TWO = 4'hA;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int CTL1_WRITE_COLL = 7;
	localparam int CTL1_PORT_EN = 5;
	localparam int CTL2_ACK_STAT = 6;
	localparam int CTL2_ACK_EN = 4;
	localparam int CTL2_STOP_EN = 2;
	localparam int CTL2_RESTART_EN = 1;
	localparam int CTL2_START_EN = 0;
	localparam int STAT_STOP_SEEN = 4;
	localparam int STAT_START_SEEN = 3;
	localparam int STAT_TX_BUSY = 2;
	localparam int STAT_BUF_FULL = 0;
	localparam int IRQ_BIT = 3;

	// ------------------------------------------------------------
	// Modes, reset values, divider constants
	// ------------------------------------------------------------
	localparam logic [3:0] MODE_TWI_MASTER = 4'h8;
	localparam logic [3:0] MODE_SPI_MASTER_DIV = 4'hA;
	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam logic [7:0] IO_MASK = 8'h3F;
	// Core clocks per divider step: half bus period = 2*(reload+1) clocks
	localparam logic PRESCALE_LAST = 1'b1;
	localparam logic [7:0] DIV_ZERO = 8'h00;
	localparam logic [3:0] TWI_BITS = 4'h9;
	localparam logic [3:0] SPI_BITS = 4'h8;
	localparam logic [3:0] ACK_SLOT = 4'h1;

	typedef enum logic [13:0] {
		ST_IDLE = 14'b00_0000_0000_0001,
		ST_START_CHK = 14'b00_0000_0000_0010,
		ST_START_CNT1 = 14'b00_0000_0000_0100,
		ST_START_CNT2 = 14'b00_0000_0000_1000,
		ST_RS_SDA = 14'b00_0000_0001_0000,
		ST_RS_CNT0 = 14'b00_0000_0010_0000,
		ST_RS_SCLH = 14'b00_0000_0100_0000,
		ST_RS_CNT1 = 14'b00_0000_1000_0000,
		ST_RS_CNT2 = 14'b00_0001_0000_0000,
		ST_SP_SDA = 14'b00_0010_0000_0000,
		ST_SP_SCLH = 14'b00_0100_0000_0000,
		ST_SP_CNT0 = 14'b00_1000_0000_0000,
		ST_SP_CNT1 = 14'b01_0000_0000_0000,
		ST_TX = 14'b10_0000_0000_0000
	} mcbrg_state_t;

	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} mcbrg_bus_req_t;

	typedef struct packed {
		logic sda_oe;
		logic scl_oe;
	} mcbrg_pins_t;
endpackage
`default_nettype wire

// ===== testbench/mcbrg_bus_peer.sv
// Partner: other masters and slaves sharing the pulled-up two-wire bus
`default_nettype none
module mcbrg_bus_peer (
	input wire logic clk_in,
	input wire logic sda_oe_in,
	input wire logic scl_oe_in,
	input wire logic sda_low_in,
	input wire logic scl_low_in,
	input wire logic [3:0] stretch_in,
	output logic sda_out,
	output logic scl_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] hold_ff = 4'h0;
	logic scl_oe_d_ff = 1'b0;
	logic stretch;
	// Clock arbitration: a slow peer keeps SCL low after the device lets go
	assign stretch = (hold_ff != 4'h0) || (scl_oe_d_ff && !scl_oe_in && stretch_in != 4'h0);
	always_ff @(posedge clk_in) begin
		scl_oe_d_ff <= scl_oe_in;
		if (scl_oe_d_ff && !scl_oe_in) begin
			hold_ff <= (stretch_in == 4'h0) ? 4'h0 : stretch_in - 4'h1;
		end else if (hold_ff != 4'h0) begin
			hold_ff <= hold_ff - 4'h1;
		end
	end
	// Pull-ups: a released line reads high
	assign sda_out = !(sda_oe_in | sda_low_in);
	assign scl_out = !(scl_oe_in | scl_low_in | stretch);
endmodule
`default_nettype wire

// ===== testbench/mcbrg_core_asserts.sv
// Checker: port-level properties of the collision and baud divider block
`default_nettype none
module mcbrg_core_asserts (
	input wire logic core_clk_in,
	input wire logic reset_in,
	input wire logic [3:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic [7:0] reg_rdata_out,
	input wire logic sda_in,
	input wire logic sda_out,
	input wire logic sda_oe_out,
	input wire logic scl_in,
	input wire logic scl_out,
	input wire logic scl_oe_out,
	input wire logic irq_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] reload_ff;
	logic seq_ff;
	logic scl_d_ff;
	logic en_one_ff;
	logic [9:0] sda_cnt_ff;
	logic [9:0] half;
	assign half = {1'b0, reload_ff, 1'b0} + 10'h002;
	always_ff @(posedge core_clk_in or posedge reset_in) begin
		if (reset_in) begin
			reload_ff <= 8'h00;
			en_one_ff <= 1'b0;
			sda_cnt_ff <= 10'h000;
			seq_ff <= 1'b0;
			scl_d_ff <= 1'b0;
		end else begin
			if (reg_wr_in && reg_addr_in == mcbrg_pkg::ADDR_RELOAD) begin
				reload_ff <= reg_wdata_in;
			end
			if (reg_wr_in && reg_addr_in == mcbrg_pkg::ADDR_IRQ_EN_ONE) begin
				en_one_ff <= reg_wdata_in[mcbrg_pkg::IRQ_BIT];
			end
			// Saturates so a long hold never wraps back to zero
			if (!sda_oe_out) begin
				sda_cnt_ff <= 10'h000;
			end else if (sda_cnt_ff != 10'h3FF) begin
				sda_cnt_ff <= sda_cnt_ff + 10'h001;
			end
			// Start or restart pending: ends once SCL is pulled or irq_out is raised, by a collision with ie2 set or by a completion with ie1 set
			scl_d_ff <= scl_oe_out;
			if (reg_wr_in && reg_addr_in == mcbrg_pkg::ADDR_CTL_TWO) begin
				seq_ff <= reg_wdata_in[mcbrg_pkg::CTL2_START_EN]
					|| reg_wdata_in[mcbrg_pkg::CTL2_RESTART_EN];
			end else if ((scl_oe_out && !scl_d_ff) || irq_out) begin
				seq_ff <= 1'b0;
			end
		end
	end
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (reset_in);
	reset_idle_a: assert property ($past(reset_in) |->
		!sda_oe_out && !scl_oe_out && !irq_out && reg_rdata_out == 8'h00) else $error("not idle after reset");
	rdata_idle_a: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 8'h00)
		else $error("read data outside read slot");
	reload_read_a: assert property ($past(reg_rd_in) && $past(reg_addr_in) == mcbrg_pkg::ADDR_RELOAD
		|-> reg_rdata_out == $past(reload_ff)) else $error("reload readback wrong");
	unmapped_read_a: assert property ($past(reg_rd_in) &&
		$past(reg_addr_in) > mcbrg_pkg::ADDR_IRQ_FLAG_TWO |-> reg_rdata_out == 8'h00)
		else $error("unmapped read not zero");
	open_drain_a: assert property (sda_out == 1'b0 && scl_out == 1'b0)
		else $error("pin drive value not low");
	coll_release_a: assert property ($rose(irq_out) && !en_one_ff && !$past(reg_wr_in) &&
		!$past(reg_wr_in, 2) |-> !sda_oe_out && !scl_oe_out) else $error("lines held after collision");
	// Transmit moves data on the same edge that pulls SCL, so only start and restart apply
	no_twin_rise_a: assert property (seq_ff |-> !($rose(sda_oe_out) && $rose(scl_oe_out)))
		else $error("both lines pulled at once");
	clock_hold_a: assert property (seq_ff && $rose(scl_oe_out) && sda_oe_out |->
		sda_cnt_ff >= half - 10'h001) else $error("SCL pulled before half period");
endmodule
bind mcbrg_core mcbrg_core_asserts u_mcbrg_core_asserts (.core_clk_in, .reset_in, .reg_addr_in,
	.reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .sda_in, .sda_out, .sda_oe_out, .scl_in,
	.scl_out, .scl_oe_out, .irq_out);
`default_nettype wire

// ===== testbench/mcbrg_core_tb_top.sv
// Testbench: register table, start/restart/stop and collision cases
`default_nettype none
module mcbrg_core_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {
		logic wr;
		logic [3:0] addr;
		logic [7:0] d;
		logic [7:0] exp;
	} mcbrg_tb_row_t;
	localparam logic [7:0] RELOAD = 8'h03;
	localparam int HALF = 2 * (int'(RELOAD) + 1);
	localparam mcbrg_tb_row_t ROWS [9] = '{
		{1'b0, mcbrg_pkg::ADDR_RELOAD, 8'h00, 8'h00},
		{1'b0, mcbrg_pkg::ADDR_CTL_TWO, 8'h00, 8'h00},
		{1'b0, mcbrg_pkg::ADDR_STATUS, 8'h00, 8'h00},
		{1'b0, mcbrg_pkg::ADDR_IRQ_FLAG_TWO, 8'h00, 8'h00},
		{1'b1, mcbrg_pkg::ADDR_MATCH_MASK, 8'hA5, 8'hA5},
		{1'b1, 4'hB, 8'hFF, 8'h00},
		{1'b1, mcbrg_pkg::ADDR_RELOAD, RELOAD, RELOAD},
		{1'b1, mcbrg_pkg::ADDR_IRQ_EN_TWO, 8'h08, 8'h08},
		{1'b1, mcbrg_pkg::ADDR_CTL_ONE, 8'h28, 8'h28}
	};
	logic clk;
	logic rst = 1'b1;
	logic [3:0] addr = 4'h0;
	logic [7:0] wdata = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [7:0] rdata;
	logic [7:0] d;
	logic sda, scl, sda_o, scl_o, sda_oe, scl_oe, irq;
	logic sda_low = 1'b0;
	logic scl_low = 1'b0;
	logic [3:0] stretch = 4'h0;
	int errors = 0;
	int compares = 0;
	int n;
	int m;
	mcbrg_core u_mcbrg_core (.core_clk_in(clk), .reset_in(rst), .reg_addr_in(addr),
		.reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .sda_in(sda),
		.sda_out(sda_o), .sda_oe_out(sda_oe), .scl_in(scl), .scl_out(scl_o), .scl_oe_out(scl_oe),
		.irq_out(irq));
	mcbrg_bus_peer u_mcbrg_bus_peer (.clk_in(clk), .sda_oe_in(sda_oe), .scl_oe_in(scl_oe),
		.sda_low_in(sda_low), .scl_low_in(scl_low), .stretch_in(stretch), .sda_out(sda), .scl_out(scl));
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// ------------------------------------------------------------
	// Bus cycles and comparisons
	// ------------------------------------------------------------
	task automatic tick(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask
	task automatic wreg(input logic [3:0] a, input logic [7:0] v);
		@(posedge clk);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rreg(input logic [3:0] a, output logic [7:0] v);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 v = rdata;
	endtask
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			errors++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic chk1(input logic got, input logic exp);
		compares++;
		if (got !== exp) begin
			errors++;
			$display("BAD %0t flag %b want %b", $time, got, exp);
		end
	endtask
	// Edges until an enable reaches the level, left in n
	task automatic wait_oe(input logic scl_sel, input logic lvl);
		n = 0;
		while ((scl_sel ? scl_oe : sda_oe) !== lvl && n < 3000) begin
			tick(1);
			n++;
		end
		chk1(n < 3000, 1'b1);
	endtask
	task automatic poll(input logic [3:0] a, input logic [7:0] mask);
		m = 0;
		d = 8'hFF;
		while ((d & mask) !== 8'h00 && m < 300) begin
			rreg(a, d);
			m++;
		end
		chk1(m < 300, 1'b1);
	endtask
	task automatic finish(input logic coll);
		poll(mcbrg_pkg::ADDR_CTL_TWO, 8'h17);
		tick(2);
		chk1(irq, coll);
		if (coll) chk1(sda_oe | scl_oe, 1'b0);
		rreg(mcbrg_pkg::ADDR_IRQ_FLAG_TWO, d);
		chk8(d, coll ? 8'h08 : 8'h00);
		rreg(mcbrg_pkg::ADDR_IRQ_FLAG_ONE, d);
		chk8(d, coll ? 8'h00 : 8'h08);
		wreg(mcbrg_pkg::ADDR_IRQ_FLAG_ONE, 8'h00);
		wreg(mcbrg_pkg::ADDR_IRQ_FLAG_TWO, 8'h00);
		tick(2);
		chk1(irq, 1'b0);
	endtask
	task automatic start_ok();
		tick(2);
		wreg(mcbrg_pkg::ADDR_CTL_TWO, 8'h01);
		finish(1'b0);
	endtask
	task automatic test_done();
		$display("errors=%0d compares=%0d", errors, compares);
		if (errors == 0 && compares > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	initial begin
		repeat (30000) @(posedge clk);
		errors++;
		$display("BAD %0t watchdog expired", $time);
		test_done();
	end
	// ------------------------------------------------------------
	// Sequence
	// ------------------------------------------------------------
	initial begin
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		foreach (ROWS[i]) begin
			if (ROWS[i].wr) wreg(ROWS[i].addr, ROWS[i].d);
			rreg(ROWS[i].addr, d);
			chk8(d, ROWS[i].exp);
		end
		wreg(mcbrg_pkg::ADDR_CTL_TWO, 8'h01);
		wait_oe(1'b0, 1'b1);
		wait_oe(1'b1, 1'b1);
		chk8(8'(n), 8'(HALF));
		finish(1'b0);
		rreg(mcbrg_pkg::ADDR_STATUS, d);
		chk8(d & 8'h18, 8'h08);
		wreg(mcbrg_pkg::ADDR_SHIFT_BUF, 8'hA5);
		wait_oe(1'b1, 1'b0);
		wait_oe(1'b1, 1'b1);
		wait_oe(1'b1, 1'b0);
		m = n;
		wait_oe(1'b1, 1'b1);
		// High half also waits for the synchronised SCL, so the low half is the pure count
		chk8(8'(m), 8'(HALF));
		chk1(m + n >= 2 * HALF && m + n <= 2 * HALF + 4, 1'b1);
		wreg(mcbrg_pkg::ADDR_SHIFT_BUF, 8'h3C);
		rreg(mcbrg_pkg::ADDR_CTL_ONE, d);
		chk8(d & 8'h80, 8'h80);
		poll(mcbrg_pkg::ADDR_STATUS, 8'h05);
		tick(40);
		chk1(scl_oe, 1'b1);
		wreg(mcbrg_pkg::ADDR_CTL_ONE, 8'h28);
		wreg(mcbrg_pkg::ADDR_IRQ_FLAG_ONE, 8'h00);
		// Slow peer stretches SCL during the stop
		stretch = 4'h5;
		wreg(mcbrg_pkg::ADDR_CTL_TWO, 8'h04);
		wait_oe(1'b1, 1'b0);
		wait_oe(1'b0, 1'b0);
		chk1(n >= HALF + 5, 1'b1);
		finish(1'b0);
		stretch = 4'h0;
		rreg(mcbrg_pkg::ADDR_STATUS, d);
		chk8(d & 8'h18, 8'h10);
		for (int i = 0; i < 3; i++) begin
			sda_low = (i == 0);
			scl_low = (i == 1);
			tick(2);
			wreg(mcbrg_pkg::ADDR_CTL_TWO, 8'h01);
			tick(4);
			scl_low = (i == 1) || (i == 2);
			tick(4);
			sda_low = 1'b0;
			scl_low = 1'b0;
			finish(1'b1);
		end
		tick(2);
		wreg(mcbrg_pkg::ADDR_CTL_TWO, 8'h01);
		tick(3);
		sda_low = 1'b1;
		wait_oe(1'b0, 1'b1);
		chk1(n < 6, 1'b1);
		sda_low = 1'b0;
		finish(1'b0);
		wreg(mcbrg_pkg::ADDR_CTL_TWO, 8'h02);
		finish(1'b0);
		stretch = 4'h3;
		wreg(mcbrg_pkg::ADDR_CTL_TWO, 8'h02);
		wait_oe(1'b1, 1'b0);
		sda_low = 1'b1;
		finish(1'b1);
		sda_low = 1'b0;
		stretch = 4'h0;
		start_ok();
		wreg(mcbrg_pkg::ADDR_CTL_TWO, 8'h02);
		wait_oe(1'b1, 1'b0);
		tick(6);
		scl_low = 1'b1;
		tick(4);
		scl_low = 1'b0;
		finish(1'b1);
		tick(2);
		wreg(mcbrg_pkg::ADDR_CTL_TWO, 8'h01);
		wait_oe(1'b0, 1'b1);
		tick(2);
		scl_low = 1'b1;
		tick(2);
		scl_low = 1'b0;
		finish(1'b0);
		wreg(mcbrg_pkg::ADDR_CTL_TWO, 8'h04);
		wait_oe(1'b0, 1'b0);
		sda_low = 1'b1;
		finish(1'b1);
		sda_low = 1'b0;
		start_ok();
		wreg(mcbrg_pkg::ADDR_CTL_TWO, 8'h04);
		wait_oe(1'b1, 1'b0);
		tick(5);
		scl_low = 1'b1;
		tick(4);
		scl_low = 1'b0;
		finish(1'b1);
		test_done();
	end
endmodule
`default_nettype wire
